// File: design/hostctl_pkg.sv
// Package: register map, field layout, reset values, codes and boot block length for host control logic
// Assumes a 16-bit host data path with word-aligned register offsets
package hostctl_pkg;
    // ========================================
    // Register offsets
    localparam logic [15:0] OFF_REQ_CTRL   = 16'h940e;
    localparam logic [15:0] OFF_LOCK       = 16'h9410;
    localparam logic [15:0] OFF_BYTE_ORDER = 16'h9412;
    localparam logic [15:0] OFF_PD_TRIG    = 16'h9416;
    localparam logic [15:0] OFF_NEG        = 16'h9418;
    localparam logic [15:0] OFF_WAKE_SEL   = 16'h940c;
    localparam logic [15:0] OFF_PAGE_CMD   = 16'h0030;
    localparam logic [15:0] OFF_PAGE_SEL   = 16'h0070;
    localparam logic [15:0] OFF_BOOT_READY = 16'h0040;
    // ========================================
    // Field positions
    localparam int REQ_EN_BIT   = 0;
    localparam int REQ_POL_BIT  = 1;
    localparam int REQ_EDGE_BIT = 2;
    localparam int PW_LSB       = 4;
    localparam int PW_MSB       = 8;
    localparam int SWAP_LO_BIT  = 0;
    localparam int SWAP_HI_BIT  = 8;
    localparam int PD_BIT       = 0;
    localparam int LOCK_BIT     = 0;
    localparam int WAKE_BIT     = 8;
    localparam int SEQ_BIT      = 7;
    localparam int NEG_W        = 10;
    // ========================================
    // Reset values and codes
    localparam logic [4:0]  PW_RESET    = 5'h04;
    localparam logic [9:0]  NEG_RESET   = 10'h004;
    localparam logic [7:0]  UNLOCK_CODE = 8'h71;
    localparam logic [7:0]  MAX_PAGES   = 8'hfe;
    localparam logic [15:0] PAGE_WORDS  = 16'h0200;
    // Boot block length in words before clock source returns to strobes
    localparam logic [15:0] BOOT_WORDS  = 16'h0400;
    typedef enum logic [1:0] {
        DL_IDLE = 2'b00,
        DL_BUSY = 2'b01
    } dl_state_t;
endpackage : hostctl_pkg

// File: design/req_pulse_gen.sv
// Transfer request pin generator, level or pulse mode
// Assumes data_ready and words_left are from the transfer engine, synchronous to clock
`timescale 1ns/1ps
module req_pulse_gen (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst_sync_n,
    // Configuration
    input  wire logic       req_en,
    input  wire logic       req_pol,
    input  wire logic       req_edge,
    input  wire logic [4:0] pulse_len,
    input  wire logic [9:0] early_negation_count,
    // Transfer status
    input  wire logic       data_ready,
    input  wire logic [15:0] words_left,
    // Pin
    output logic            transfer_request_pin,
    output logic            transfer_request_oe_n
);
    // ========================================
    // Pulse counter
    logic [5:0] cnt_r;
    logic       ready_d_r;
    logic       active;
    logic       level_act;
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cnt_r     <= 6'h00;
            ready_d_r <= 1'b0;
        end else begin
            ready_d_r <= data_ready;
            if (data_ready && !ready_d_r && req_edge && req_en) begin
                cnt_r <= {1'b0, pulse_len};
            end else if (cnt_r != 6'h00) begin
                cnt_r <= cnt_r - 6'h01;
            end
        end
    end
    // Negate once remaining words fall to the count; host keeps count below size
    assign level_act = data_ready && (words_left > {6'h00, early_negation_count});
    assign active = (pulse_len != 5'h00) && req_en &&
                    (req_edge ? (cnt_r != 6'h00) : level_act);
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            transfer_request_pin  <= 1'b1;
            transfer_request_oe_n <= 1'b1;
        end else begin
            transfer_request_pin  <= active ^ req_pol;
            transfer_request_oe_n <= !req_en;
        end
    end
    pulse_width_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
        (data_ready && !ready_d_r && req_edge && req_en && pulse_len == 5'h03 && cnt_r == 6'h00)
        |=> (cnt_r == 6'h03) ##1 (cnt_r == 6'h02) ##1 (cnt_r == 6'h01) ##1 (cnt_r == 6'h00))
        else $error("Pulse length wrong");
    zero_width_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
        (pulse_len == 5'h00) |=> (transfer_request_pin == $past(req_pol)))
        else $error("Request asserted with zero width");
    level_neg_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
        (!req_edge && req_en && data_ready && pulse_len != 5'h00
         && words_left <= {6'h00, early_negation_count})
        |=> (transfer_request_pin == $past(req_pol)))
        else $error("Level request not negated early");
    drive_en_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
        !req_en |=> transfer_request_oe_n)
        else $error("Pin driven while disabled");
endmodule : req_pulse_gen

// File: design/host_control_regs.sv
// Host control registers and paged boot logic of an embedded flash drive
// Assumes host bus strobes are synchronous to clock and active low; page fetch done by flash engine
`timescale 1ns/1ps
module host_control_regs (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // Host bus
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic [15:0] addr,
    input  wire logic [15:0] wdata,
    output logic [15:0]      rdata,
    output logic             rdata_oe_n,
    output logic             busy_n,
    // Configuration
    input  wire logic        device_id0,
    input  wire logic        boot_mode,
    // Flash engine and transfer status
    input  wire logic        data_ready,
    input  wire logic [15:0] words_left,
    input  wire logic        page_done,
    input  wire logic [15:0] boot_word,
    // Block controls
    output logic             deep_sleep_mode,
    output logic             protected_blocked,
    output logic             strobe_clock_sel,
    output logic             page_load_req,
    output logic [7:0]       page_index,
    output logic [15:0]      swapped_wdata,
    // Request pin
    output logic             transfer_request_pin,
    output logic             transfer_request_oe_n
);
    // ========================================
    // Reset synchroniser
    logic rst_s1_r;
    logic rst_sync_n;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_r   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_s1_r   <= 1'b1;
            rst_sync_n <= rst_s1_r;
        end
    end
    // ========================================
    // Bus decode
    function automatic logic swap16_en(input logic en);
        swap16_en = en;
    endfunction : swap16_en
    function automatic logic [15:0] swap16(input logic [15:0] d, input logic en);
        swap16 = en ? {d[7:0], d[15:8]} : d;
    endfunction : swap16
    logic        we_d_r;
    logic        wr_pulse;
    logic        rd_act;
    logic        swap_r;
    logic [15:0] wd;
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            we_d_r <= 1'b1;
        end else begin
            we_d_r <= we_n;
        end
    end
    // One write per falling edge of write strobe; edge-sensitive bus
    assign wr_pulse = !ce_n && !we_n && we_d_r;
    assign rd_act   = !ce_n && !oe_n;
    assign wd       = swap16(wdata, swap16_en(swap_r));
    // ========================================
    // Control registers
    logic       req_en_r;
    logic       req_pol_r;
    logic       req_edge_r;
    logic [4:0] pw_r;
    logic [9:0] neg_r;
    logic       lock_r;
    logic       wake_sel_r;
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            req_en_r   <= 1'b0;
            req_pol_r  <= 1'b1;
            req_edge_r <= 1'b0;
            pw_r       <= hostctl_pkg::PW_RESET;
        end else if (wr_pulse && addr == hostctl_pkg::OFF_REQ_CTRL) begin
            req_en_r   <= wd[hostctl_pkg::REQ_EN_BIT];
            req_pol_r  <= wd[hostctl_pkg::REQ_POL_BIT];
            req_edge_r <= wd[hostctl_pkg::REQ_EDGE_BIT];
            pw_r       <= wd[hostctl_pkg::PW_MSB:hostctl_pkg::PW_LSB];
        end
    end
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            neg_r <= hostctl_pkg::NEG_RESET;
        end else if (wr_pulse && addr == hostctl_pkg::OFF_NEG) begin
            neg_r <= wd[hostctl_pkg::NEG_W-1:0];
        end
    end
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            lock_r <= 1'b0;
        end else if (wr_pulse && addr == hostctl_pkg::OFF_LOCK && wd[hostctl_pkg::LOCK_BIT]) begin
            lock_r <= 1'b1;
        end
    end
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            swap_r <= 1'b0;
        end else if (wr_pulse && addr == hostctl_pkg::OFF_BYTE_ORDER) begin
            // Either lane sets, so the host's own byte order does not matter
            swap_r <= wdata[hostctl_pkg::SWAP_LO_BIT] | wdata[hostctl_pkg::SWAP_HI_BIT];
        end
    end
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            wake_sel_r <= 1'b0;
        end else if (wr_pulse && addr == hostctl_pkg::OFF_WAKE_SEL) begin
            wake_sel_r <= wd[hostctl_pkg::WAKE_BIT];
        end
    end
    // ========================================
    // Deep sleep entry and wake
    logic wake_evt;
    assign wake_evt = wake_sel_r ? (!ce_n && (!oe_n || !we_n)) : !ce_n;
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            deep_sleep_mode <= 1'b0;
        end else if (wr_pulse && addr == hostctl_pkg::OFF_PD_TRIG && wd[hostctl_pkg::PD_BIT]) begin
            deep_sleep_mode <= 1'b1;
        end else if (deep_sleep_mode && wake_evt && !wr_pulse) begin
            deep_sleep_mode <= 1'b0;
        end
    end
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            protected_blocked <= 1'b0;
        end else begin
            protected_blocked <= lock_r;
        end
    end
    // ========================================
    // Paged boot download
    hostctl_pkg::dl_state_t state_r;
    logic       unlocked_r;
    logic [7:0] pages_r;
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            unlocked_r <= 1'b0;
        end else if (wr_pulse) begin
            // Only the write directly after the unlock may use it
            unlocked_r <= (addr == hostctl_pkg::OFF_PAGE_CMD) &&
                          (wd[7:0] == hostctl_pkg::UNLOCK_CODE);
        end
    end
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_r       <= hostctl_pkg::DL_BUSY;
            page_load_req <= 1'b1;
            page_index    <= 8'h00;
            pages_r       <= 8'h00;
        end else begin
            page_load_req <= 1'b0;
            unique case (state_r)
                hostctl_pkg::DL_IDLE: begin
                    if (wr_pulse && addr == hostctl_pkg::OFF_PAGE_SEL && unlocked_r
                        && device_id0 == 1'b0 && pages_r < hostctl_pkg::MAX_PAGES) begin
                        state_r       <= hostctl_pkg::DL_BUSY;
                        page_load_req <= 1'b1;
                        pages_r       <= pages_r + 8'h01;
                        page_index    <= wd[hostctl_pkg::SEQ_BIT] ? page_index + 8'h01
                                                                  : 8'h00;
                    end
                end
                hostctl_pkg::DL_BUSY: begin
                    if (page_done) begin
                        state_r      <= hostctl_pkg::DL_IDLE;
                    end
                end
                default: begin
                    state_r <= hostctl_pkg::DL_IDLE;
                end
            endcase
        end
    end
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            busy_n <= 1'b1;
        end else begin
            busy_n <= 1'b1;
        end
    end
    // ========================================
    // Async boot fetch and clock source
    logic [15:0] boot_cnt_r;
    logic [15:0] addr_d_r;
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            boot_cnt_r       <= 16'h0000;
            addr_d_r         <= 16'h0000;
            strobe_clock_sel <= 1'b0;
        end else begin
            addr_d_r <= addr;
            if (boot_mode && !strobe_clock_sel && rd_act && addr != addr_d_r) begin
                boot_cnt_r <= boot_cnt_r + 16'h0001;
                if (boot_cnt_r == hostctl_pkg::BOOT_WORDS - 16'h0001) begin
                    strobe_clock_sel <= 1'b1;
                end
            end
            if (!boot_mode) begin
                strobe_clock_sel <= 1'b1;
            end
        end
    end
    // ========================================
    // Read mux
    logic [15:0] rd_nxt;
    always_comb begin
        rd_nxt = 16'h0000;
        if (boot_mode && !strobe_clock_sel) begin
            rd_nxt = boot_word;
        end else begin
            unique case (addr)
                hostctl_pkg::OFF_REQ_CTRL: begin
                    rd_nxt = {7'h00, pw_r, 1'b0, req_edge_r, req_pol_r, req_en_r};
                end
                hostctl_pkg::OFF_NEG: rd_nxt = {6'h00, neg_r};
                hostctl_pkg::OFF_LOCK: rd_nxt = {15'h0000, lock_r};
                hostctl_pkg::OFF_BYTE_ORDER: rd_nxt = {7'h00, swap_r, 7'h00, swap_r};
                hostctl_pkg::OFF_WAKE_SEL: rd_nxt = {7'h00, wake_sel_r, 8'h00};
                hostctl_pkg::OFF_BOOT_READY: begin
                    rd_nxt = {15'h0000, state_r == hostctl_pkg::DL_IDLE};
                end
                default: rd_nxt = 16'h0000;
            endcase
        end
    end
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rdata         <= 16'h0000;
            rdata_oe_n    <= 1'b1;
            swapped_wdata <= 16'h0000;
        end else begin
            rdata         <= swap16(rd_nxt, swap_r);
            rdata_oe_n    <= !rd_act;
            swapped_wdata <= wd;
        end
    end
    // ========================================
    // Request pin
    req_pulse_gen u_req (
        .clock                (clock),
        .rst_sync_n           (rst_sync_n),
        .req_en               (req_en_r),
        .req_pol              (req_pol_r),
        .req_edge             (req_edge_r),
        .pulse_len            (pw_r),
        .early_negation_count (neg_r),
        .data_ready           (data_ready),
        .words_left           (words_left),
        .transfer_request_pin (transfer_request_pin),
        .transfer_request_oe_n(transfer_request_oe_n)
    );
    // ========================================
    // Checks
    pd_entry_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
        (wr_pulse && addr == hostctl_pkg::OFF_PD_TRIG && wd[0]) |=> deep_sleep_mode)
        else $error("Deep sleep not entered");
    lock_sticky_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
        lock_r |=> lock_r ##1 protected_blocked)
        else $error("Lock cleared");
    lock_block_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
        $rose(lock_r) |=> protected_blocked)
        else $error("Lock not blocking");
    swap_set_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
        (wr_pulse && addr == hostctl_pkg::OFF_BYTE_ORDER && (wdata[0] | wdata[8])) |=> swap_r)
        else $error("Swap not set");
    swap_data_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
        swap_r && $stable(swap_r) |-> swapped_wdata == {$past(wdata[7:0]), $past(wdata[15:8])})
        else $error("Data not swapped");
    page_unlock_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
        (wr_pulse && addr == hostctl_pkg::OFF_PAGE_SEL && !unlocked_r) |=> !page_load_req)
        else $error("Page select taken without unlock");
    busy_quiet_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
        (state_r == hostctl_pkg::DL_BUSY) |-> busy_n)
        else $error("Busy asserted during download");
    cascade_block_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
        (device_id0 && state_r == hostctl_pkg::DL_IDLE) |=> !page_load_req)
        else $error("Second device downloading");
    fill_req_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
        $rose(rst_sync_n) |-> (page_load_req && state_r == hostctl_pkg::DL_BUSY))
        else $error("No fill after reset");
    seq_page_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
        (page_load_req && $past(state_r == hostctl_pkg::DL_IDLE && wd[hostctl_pkg::SEQ_BIT]))
        |-> (page_index == $past(page_index) + 8'h01))
        else $error("Sequential page not next");
    page_zero_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
        (page_load_req && $past(state_r == hostctl_pkg::DL_IDLE && !wd[hostctl_pkg::SEQ_BIT]))
        |-> (page_index == 8'h00))
        else $error("Fixed page not zero");
    boot_word_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
        (boot_mode && !strobe_clock_sel) |=> (rdata == $past(swap16(boot_word, swap_r))))
        else $error("Boot word not returned");
    boot_done_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
        (boot_mode && rd_act && addr != addr_d_r
         && boot_cnt_r == hostctl_pkg::BOOT_WORDS - 16'h0001) |=> strobe_clock_sel)
        else $error("Clock source not returned");
    reserved_bits_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
        (rd_act && strobe_clock_sel && addr == hostctl_pkg::OFF_LOCK)
        |=> ((rdata & 16'hfefe) == 16'h0000))
        else $error("Reserved lock bits set");
    cs_wake_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
        (deep_sleep_mode && !wake_sel_r && !ce_n && !wr_pulse) |=> !deep_sleep_mode)
        else $error("Chip select did not wake");
    access_wake_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
        (deep_sleep_mode && wake_sel_r && oe_n && we_n) |=> deep_sleep_mode)
        else $error("Woken without access");
endmodule : host_control_regs

// File: tb/flash_engine_model.sv
// Flash engine stand-in: serves page loads and hands out boot block words
// Assumes page_load_req is a one-cycle pulse and addr is the host byte address
`timescale 1ns/1ps
module flash_engine_model #(
    parameter int LOAD_CYCLES = 20
) (
    // Clock
    input  wire logic        clock,
    // Block side
    input  wire logic        page_load_req,
    input  wire logic [15:0] addr,
    output logic             page_done,
    output logic [15:0]      boot_word
);
    // ========================================
    // Page load timing
    int unsigned wait_cnt = 0;
    initial page_done = 1'b0;
    always @(posedge clock) begin
        page_done <= 1'b0;
        if (page_load_req === 1'b1) begin
            wait_cnt <= LOAD_CYCLES;
        end else if (wait_cnt == 1) begin
            page_done <= 1'b1;
            wait_cnt  <= 0;
        end else if (wait_cnt != 0) begin
            wait_cnt <= wait_cnt - 1;
        end
    end
    // ========================================
    // Boot data
    // Word changes with every address, so a stale word never matches
    assign boot_word = addr ^ 16'ha5c3;
endmodule : flash_engine_model

// File: tb/tb_host_control_regs.sv
// Self-checking bench for the host control registers
// Assumes the flash engine model in flash_engine_model.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
    $display("FAIL %s expected %h seen %h", n, e, g); end end
module tb_host_control_regs;
    logic        clock, rst_n, ce_n, oe_n, we_n, device_id0, boot_mode, data_ready;
    logic [15:0] addr, wdata, words_left, rdata, boot_word, swapped_wdata, v;
    logic        rdata_oe_n, busy_n, page_done, deep_sleep_mode, protected_blocked;
    logic        strobe_clock_sel, page_load_req, transfer_request_pin, transfer_request_oe_n;
    logic [7:0]  page_index;
    logic [15:0] cfg [4] = '{16'h0035, 16'h0037, 16'h01f5, 16'h0001};
    int          pw [4] = '{3, 3, 31, 0};
    int          bad_count = 0, checks = 0, reqs = 0, n;
    // ========================================
    // Clock, partner and design
    initial begin
        clock = 0;
        forever #12.5 clock = ~clock;
    end
    always @(posedge clock) if (page_load_req === 1'b1) reqs++;
    flash_engine_model #(.LOAD_CYCLES(40)) partner (.clock, .page_load_req, .addr,
        .page_done, .boot_word);
    host_control_regs dut (.clock, .rst_n, .ce_n, .oe_n, .we_n, .addr, .wdata, .rdata,
        .rdata_oe_n, .busy_n, .device_id0, .boot_mode, .data_ready, .words_left,
        .page_done, .boot_word, .deep_sleep_mode, .protected_blocked, .strobe_clock_sel,
        .page_load_req, .page_index, .swapped_wdata, .transfer_request_pin,
        .transfer_request_oe_n);
    // ========================================
    // Bus tasks
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge clock);
        {ce_n, we_n, addr, wdata} = {2'b00, a, d};
        @(negedge clock);
        {ce_n, we_n} = 2'b11;
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(negedge clock);
        {ce_n, oe_n, addr} = {2'b00, a};
        repeat (2) @(negedge clock);
        d = rdata;
        {ce_n, oe_n} = 2'b11;
    endtask : rd
    task automatic chk_rd(input string nm, input logic [15:0] a, input logic [15:0] e);
        rd(a, v);
        `CHK(nm, e, v)
    endtask : chk_rd
    task automatic do_reset(input logic bm);
        boot_mode = bm;
        rst_n = 0;
        repeat (2) @(negedge clock);
        `CHK("fill request", 1'b1, page_load_req)
        rst_n = 1;
        repeat (6) @(negedge clock);
        reqs = 0;
    endtask : do_reset
    task automatic page_sel(input logic [15:0] d, input bit unlock);
        if (unlock) wr(hostctl_pkg::OFF_PAGE_CMD, 16'h0071);
        wr(hostctl_pkg::OFF_PAGE_SEL, d);
        repeat (3) @(negedge clock);
    endtask : page_sel
    task automatic poll_ready();
        v = 0;
        // Bounded so a download that never ends shows up as a mismatch
        for (int i = 0; i < 60 && v[0] !== 1'b1; i++) begin
            rd(hostctl_pkg::OFF_BOOT_READY, v);
            `CHK("busy", 1'b1, busy_n)
        end
        `CHK("ready", 1'b1, v[0])
    endtask : poll_ready
    task automatic pulse_cnt(input logic act, output int c);
        c = 0;
        repeat (40) @(negedge clock) if (transfer_request_pin === act) c++;
    endtask : pulse_cnt
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : final_report
    // ========================================
    // Watchdog
    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        final_report();
    end
    // ========================================
    // Tests
    initial begin
        {rst_n, ce_n, oe_n, we_n, device_id0, boot_mode, data_ready} = 7'b0111000;
        {addr, wdata, words_left} = '0;
        do_reset(1'b0);
        chk_rd("req ctrl", hostctl_pkg::OFF_REQ_CTRL, 16'h0042);
        chk_rd("negation", hostctl_pkg::OFF_NEG, 16'h0004);
        chk_rd("lock", hostctl_pkg::OFF_LOCK, 16'h0000);
        `CHK("pin oe", 1'b1, transfer_request_oe_n)
        `CHK("strobe clock", 1'b1, strobe_clock_sel)
        wr(hostctl_pkg::OFF_REQ_CTRL, 16'hffff);
        chk_rd("req reserved", hostctl_pkg::OFF_REQ_CTRL, 16'h01f7);
        wr(hostctl_pkg::OFF_NEG, 16'hffff);
        chk_rd("neg reserved", hostctl_pkg::OFF_NEG, 16'h03ff);
        wr(hostctl_pkg::OFF_WAKE_SEL, 16'hffff);
        chk_rd("wake reserved", hostctl_pkg::OFF_WAKE_SEL, 16'h0100);
        $display("reset and reserved test done");
        wr(hostctl_pkg::OFF_LOCK, 16'h0001);
        wr(hostctl_pkg::OFF_LOCK, 16'h0000);
        chk_rd("lock sticky", hostctl_pkg::OFF_LOCK, 16'h0001);
        `CHK("blocked", 1'b1, protected_blocked)
        $display("lock test done");
        wr(hostctl_pkg::OFF_BYTE_ORDER, 16'h0001);
        wr(hostctl_pkg::OFF_NEG, 16'h0312);
        chk_rd("swapped read", hostctl_pkg::OFF_NEG, 16'h0302);
        wr(hostctl_pkg::OFF_BYTE_ORDER, 16'h0000);
        chk_rd("plain read", hostctl_pkg::OFF_NEG, 16'h0203);
        for (int i = 0; i < 3; i++) begin
            wr(hostctl_pkg::OFF_BYTE_ORDER, i == 0 ? 16'h0100 : (i == 1 ? 16'h0001 : 16'h0));
            wdata = 16'h1234;
            repeat (2) @(negedge clock);
            `CHK("swap data", i < 2 ? 16'h3412 : 16'h1234, swapped_wdata)
        end
        $display("byte swap test done");
        for (int i = 0; i < 2; i++) begin
            wr(hostctl_pkg::OFF_WAKE_SEL, i == 0 ? 16'h0000 : 16'h0100);
            wr(hostctl_pkg::OFF_PD_TRIG, 16'h0001);
            @(negedge clock);
            `CHK("sleep entry", 1'b1, deep_sleep_mode)
            ce_n = 0;
            @(negedge clock);
            ce_n = 1;
            repeat (2) @(negedge clock);
            `CHK("chip select wake", i == 0 ? 1'b0 : 1'b1, deep_sleep_mode)
        end
        rd(hostctl_pkg::OFF_LOCK, v);
        repeat (2) @(negedge clock);
        `CHK("access wake", 1'b0, deep_sleep_mode)
        $display("power down test done");
        // Level mode with zero width would drive the pin if the width gate were lost
        words_left = 16'hffff;
        for (int i = 0; i < 4; i++) begin
            wr(hostctl_pkg::OFF_REQ_CTRL, cfg[i]);
            @(negedge clock);
            data_ready = 1;
            pulse_cnt(!cfg[i][1], n);
            `CHK("pulse width", pw[i], n)
            data_ready = 0;
        end
        wr(hostctl_pkg::OFF_REQ_CTRL, 16'h0034);
        repeat (2) @(negedge clock);
        `CHK("pin released", 1'b1, transfer_request_oe_n)
        wr(hostctl_pkg::OFF_NEG, 16'h0004);
        words_left = 16'd10;
        wr(hostctl_pkg::OFF_REQ_CTRL, 16'h0041);
        data_ready = 1;
        repeat (3) @(negedge clock);
        `CHK("level on", 1'b1, transfer_request_pin)
        `CHK("pin driven", 1'b0, transfer_request_oe_n)
        words_left = 16'd5;
        repeat (2) @(negedge clock);
        `CHK("level above count", 1'b1, transfer_request_pin)
        words_left = 16'd4;
        repeat (2) @(negedge clock);
        `CHK("level negated", 1'b0, transfer_request_pin)
        data_ready = 0;
        $display("request pin test done");
        page_sel(16'h0080, 1);
        `CHK("seq page", 8'h01, page_index)
        poll_ready();
        page_sel(16'h0080, 0);
        page_sel(16'h0005, 1);
        `CHK("page zero", 8'h00, page_index)
        poll_ready();
        device_id0 = 1;
        page_sel(16'h0080, 1);
        `CHK("load count", 2, reqs)
        device_id0 = 0;
        $display("paged boot test done");
        do_reset(1'b1);
        `CHK("lock cleared", 1'b0, protected_blocked)
        `CHK("boot clock", 1'b0, strobe_clock_sel)
        @(negedge clock);
        {ce_n, oe_n, addr} = '0;
        for (int i = 1; i <= 1030; i++) begin
            @(negedge clock);
            if (i == 6) `CHK("boot word", 16'h000a ^ 16'ha5c3, rdata)
            if (i == 6) `CHK("read drive", 1'b0, rdata_oe_n)
            addr = addr + 16'h0002;
        end
        {ce_n, oe_n} = 2'b11;
        repeat (3) @(negedge clock);
        `CHK("boot done", 1'b1, strobe_clock_sel)
        `CHK("read idle", 1'b1, rdata_oe_n)
        $display("boot test done");
        final_report();
    end
endmodule : tb_host_control_regs
